// ---- logic/ipr_regs.sv ----
// Purpose: APB register file for priority control registers 11 to 16.
// Assumes: Zero-wait APB slave; clock 40 MHz; inputs synchronous.
// Notes:   Fields go straight from flops to arbitration, so a write acts next cycle.

`timescale 1ns/100ps
`default_nettype none

module ipr_regs (
   input  wire logic        clock,
   input  wire logic        rst,
   input  wire logic        psel,
   input  wire logic        penable,
   input  wire logic        pwrite,
   input  wire logic [11:0] paddr,
   input  wire logic [31:0] pwdata,
   input  wire logic [3:0]  pstrb,
   output logic             pready,
   output logic      [31:0] prdata,
   output logic             pslverr,
   output logic      [2:0]  timer6_prio,
   output logic      [2:0]  dma_ch4_done_prio,
   output logic      [2:0]  out_compare8_prio,
   output logic      [2:0]  timer8_prio,
   output logic      [2:0]  i2c_second_master_prio,
   output logic      [2:0]  i2c_second_slave_prio,
   output logic      [2:0]  timer7_prio,
   output logic      [2:0]  can_second_rx_ready_prio,
   output logic      [2:0]  ext_irq4_prio,
   output logic      [2:0]  ext_irq3_prio,
   output logic      [2:0]  timer9_prio,
   output logic      [2:0]  codec_if_error_prio,
   output logic      [2:0]  can_second_event_prio,
   output logic      [2:0]  dma_ch5_done_prio,
   output logic      [2:0]  codec_if_event_prio,
   output logic      [2:0]  uart_second_error_prio,
   output logic      [2:0]  uart_first_error_prio,
   output logic      [16:0] srcEnabled
);

   // ----------------------------------------------------------------
   // Address decode
   // ----------------------------------------------------------------
   localparam int NF = 17;

   // Register index of an address, or NUM_REGS when unmapped.
   function automatic logic [2:0] regIndex(input logic [11:0] addr);
      case (addr)
         ipr_pkg::OFS_IRQ_PRIORITY_CTRL_11: regIndex = 3'h0;
         ipr_pkg::OFS_IRQ_PRIORITY_CTRL_12: regIndex = 3'h1;
         ipr_pkg::OFS_IRQ_PRIORITY_CTRL_13: regIndex = 3'h2;
         ipr_pkg::OFS_IRQ_PRIORITY_CTRL_14: regIndex = 3'h3;
         ipr_pkg::OFS_IRQ_PRIORITY_CTRL_15: regIndex = 3'h4;
         ipr_pkg::OFS_IRQ_PRIORITY_CTRL_16: regIndex = 3'h5;
         default:            regIndex = 3'h6;
      endcase
   endfunction

   // Field table: register index and low bit position of each field.
   localparam logic [2:0] FREG [NF] = '{
      3'h0, 3'h0, 3'h0,
      3'h1, 3'h1, 3'h1, 3'h1,
      3'h2, 3'h2, 3'h2, 3'h2,
      3'h3, 3'h3,
      3'h4, 3'h4,
      3'h5, 3'h5};
   localparam int FPOS [NF] = '{
      ipr_pkg::POS_F3, ipr_pkg::POS_F2, ipr_pkg::POS_F0,                   // R6 R7
      ipr_pkg::POS_F3, ipr_pkg::POS_F2, ipr_pkg::POS_F1, ipr_pkg::POS_F0,  // R8
      ipr_pkg::POS_F3, ipr_pkg::POS_F2, ipr_pkg::POS_F1, ipr_pkg::POS_F0,  // R9
      ipr_pkg::POS_F3, ipr_pkg::POS_F0,                                    // R10
      ipr_pkg::POS_F1, ipr_pkg::POS_F0,                                    // R11
      ipr_pkg::POS_F2, ipr_pkg::POS_F1};                                   // R12

   logic        accessPhase;
   logic        wrAccess;
   logic [2:0]  accIdx;
   logic [2:0]  prio [NF];
   logic [15:0] regView [ipr_pkg::NUM_REGS];

   assign accessPhase = psel & penable;
   assign wrAccess    = accessPhase & pwrite;
   assign accIdx      = regIndex(paddr);

   // ----------------------------------------------------------------
   // Priority fields
   // ----------------------------------------------------------------
   genvar g;
   generate
      for (g = 0; g < NF; g++) begin : gField
         logic fieldWr;
         // Each field sits in one byte lane, so its lane strobe gates it.
         assign fieldWr = wrAccess & (accIdx == FREG[g]) & pstrb[FPOS[g] / 8];
         ipr_field uField (
            .clock      (clock),
            .rst        (rst),
            .wrEn       (fieldWr),
            .wrData     (pwdata[FPOS[g] +: 3]),
            .prio       (prio[g]),
            .srcEnabled (srcEnabled[g])
         );
      end
   endgenerate

   // Only field bits are stored; unimplemented positions are constant zero.
   always_comb begin
      for (int r = 0; r < ipr_pkg::NUM_REGS; r++) begin
         regView[r] = 16'h0000;                         // R5
      end
      for (int f = 0; f < NF; f++) begin
         regView[FREG[f]][FPOS[f] +: 3] = prio[f];
      end
   end

   // ----------------------------------------------------------------
   // Arbitration outputs
   // ----------------------------------------------------------------
   assign timer6_prio              = prio[0];           // R14
   assign dma_ch4_done_prio        = prio[1];
   assign out_compare8_prio        = prio[2];
   assign timer8_prio              = prio[3];
   assign i2c_second_master_prio   = prio[4];
   assign i2c_second_slave_prio    = prio[5];
   assign timer7_prio              = prio[6];
   assign can_second_rx_ready_prio = prio[7];
   assign ext_irq4_prio            = prio[8];
   assign ext_irq3_prio            = prio[9];
   assign timer9_prio              = prio[10];
   assign codec_if_error_prio      = prio[11];
   assign can_second_event_prio    = prio[12];
   assign dma_ch5_done_prio        = prio[13];
   assign codec_if_event_prio      = prio[14];
   assign uart_second_error_prio   = prio[15];
   assign uart_first_error_prio    = prio[16];

   // ----------------------------------------------------------------
   // APB answer
   // ----------------------------------------------------------------
   // Zero-wait slave: pready is high in every access phase.
   always_ff @(posedge clock or posedge rst) begin
      if (rst) begin
         pready <= 1'b0;
      end else begin
         pready <= psel & ~penable;
      end
   end

   // Read data is registered during setup so it stands stable in the access phase.
   always_ff @(posedge clock or posedge rst) begin
      if (rst) begin
         prdata <= 32'h0000_0000;
      end else if (psel & ~penable & ~pwrite & (regIndex(paddr) < 3'(ipr_pkg::NUM_REGS))) begin
         prdata <= {16'h0000, regView[regIndex(paddr)]}; // R5
      end else begin
         prdata <= 32'h0000_0000;
      end
   end

   // Unmapped addresses answer with an error; writes there change nothing.
   always_ff @(posedge clock or posedge rst) begin
      if (rst) begin
         pslverr <= 1'b0;
      end else begin
         pslverr <= psel & ~penable & (regIndex(paddr) == 3'(ipr_pkg::NUM_REGS));
      end
   end

endmodule

`default_nettype wire

// ---- logic/ipr_pkg.sv ----
// Purpose: Constants for the interrupt priority control registers 11 to 16.
// Assumes: APB slave with 32-bit data, one aligned word per register.
// Notes:   Register offsets are a local choice of this block, one word apart.
//
// Contract
// R1: Code 111 gives priority seven, the highest.
// R2: Code 001 gives priority one; linear between.
// R3: Code 000 disables its source entirely.
// R4: Fields reset to 100, readable and writable.
// R5: Unimplemented bits read zero, ignore writes.
// R6: Reg 11 fields at 14:12, 10:8, 2:0.
// R7: Reg 11 bits 7 to 3 read zero.
// R8: Reg 12 fields 14:12, 10:8, 6:4, 2:0.
// R9: Reg 13 fields 14:12, 10:8, 6:4, 2:0.
// R10: Reg 14 fields 14:12 and 2:0 only.
// R11: Reg 15 fields 6:4 and 2:0 only.
// R12: Reg 16 fields 10:8 and 6:4 only.
// R13: All sources start at level four.
// R14: Fields drive arbitration continuously.

package ipr_pkg;

   // ----------------------------------------------------------------
   // Register map
   // ----------------------------------------------------------------
   localparam int          NUM_REGS   = 6;
   localparam logic [11:0] OFS_IRQ_PRIORITY_CTRL_11  = 12'h000;
   localparam logic [11:0] OFS_IRQ_PRIORITY_CTRL_12  = 12'h004;
   localparam logic [11:0] OFS_IRQ_PRIORITY_CTRL_13  = 12'h008;
   localparam logic [11:0] OFS_IRQ_PRIORITY_CTRL_14  = 12'h00C;
   localparam logic [11:0] OFS_IRQ_PRIORITY_CTRL_15  = 12'h010;
   localparam logic [11:0] OFS_IRQ_PRIORITY_CTRL_16  = 12'h014;

   // ----------------------------------------------------------------
   // Field layout and reset values
   // ----------------------------------------------------------------
   localparam logic [2:0]  PRIO_RESET = 3'h4;
   localparam logic [2:0]  PRIO_OFF   = 3'h0;
   localparam int          POS_F3     = 12;
   localparam int          POS_F2     = 8;
   localparam int          POS_F1     = 4;
   localparam int          POS_F0     = 0;

   // Implemented-bit masks per register, index 0 is register 11.
   localparam logic [15:0] MASK_IRQ_PRIORITY_CTRL_11 = 16'h7707;
   localparam logic [15:0] MASK_IRQ_PRIORITY_CTRL_12 = 16'h7777;
   localparam logic [15:0] MASK_IRQ_PRIORITY_CTRL_13 = 16'h7777;
   localparam logic [15:0] MASK_IRQ_PRIORITY_CTRL_14 = 16'h7007;
   localparam logic [15:0] MASK_IRQ_PRIORITY_CTRL_15 = 16'h0077;
   localparam logic [15:0] MASK_IRQ_PRIORITY_CTRL_16 = 16'h0770;

   // Reset value: top bit of each implemented field set.
   localparam logic [15:0] RESET_IRQ_PRIORITY_CTRL_11 = 16'h4404;
   localparam logic [15:0] RESET_IRQ_PRIORITY_CTRL_12 = 16'h4444;
   localparam logic [15:0] RESET_IRQ_PRIORITY_CTRL_13 = 16'h4444;
   localparam logic [15:0] RESET_IRQ_PRIORITY_CTRL_14 = 16'h4004;
   localparam logic [15:0] RESET_IRQ_PRIORITY_CTRL_15 = 16'h0044;
   localparam logic [15:0] RESET_IRQ_PRIORITY_CTRL_16 = 16'h0440;

   localparam logic [31:0] PSLVERR_NONE = 32'h0000_0000;

   typedef enum logic [1:0] {
      APB_IDLE   = 2'b00,
      APB_ACCESS = 2'b01
   } ipr_apb_state_t;

endpackage

// ---- logic/ipr_field.sv ----
// Purpose: One 3-bit priority field with its decoded level and enable.
// Assumes: Write strobe already qualified by address and byte lane.
// Notes:   Level equals code; code zero removes the source from arbitration.

`timescale 1ns/100ps
`default_nettype none

module ipr_field (
   input  wire logic       clock,
   input  wire logic       rst,
   input  wire logic       wrEn,
   input  wire logic [2:0] wrData,
   output logic      [2:0] prio,
   output logic            srcEnabled
);

   always_ff @(posedge clock or posedge rst) begin
      if (rst) begin
         prio <= ipr_pkg::PRIO_RESET;                 // R4 R13
      end else if (wrEn) begin
         prio <= wrData;                              // R4
      end
   end

   // The code is the level itself, so 111 is seven and 001 is one.
   always_ff @(posedge clock or posedge rst) begin
      if (rst) begin
         srcEnabled <= 1'b1;
      end else if (wrEn) begin
         srcEnabled <= (wrData != ipr_pkg::PRIO_OFF); // R1 R2 R3
      end
   end

endmodule

`default_nettype wire

// ---- dv/ipr_regs_assertions.sv ----
// Purpose: Concurrent checks on the priority register block ports.
// Assumes: Zero-wait APB slave; fields update at the write edge.
// Notes:   Watches a sample of fields; the bench compares the rest.
`timescale 1ns/100ps
`default_nettype none
module ipr_regs_assertions (
   input wire logic        clock,
   input wire logic        rst,
   input wire logic        psel,
   input wire logic        penable,
   input wire logic        pwrite,
   input wire logic [11:0] paddr,
   input wire logic [31:0] pwdata,
   input wire logic [3:0]  pstrb,
   input wire logic        pready,
   input wire logic [31:0] prdata,
   input wire logic        pslverr,
   input wire logic [2:0]  timer6_prio,
   input wire logic [2:0]  out_compare8_prio,
   input wire logic [2:0]  uart_first_error_prio,
   input wire logic [16:0] srcEnabled
);
   default clocking @(posedge clock); endclocking
   default disable iff (rst);
   sequence acc_s;
      psel && penable;
   endsequence
   sequence wr11_s;
      acc_s ##0 pwrite && paddr == 12'h000;
   endsequence
   a_ready_access: assert property (acc_s |-> pready) else $error("no ready in access");
   a_upper_zero: assert property (pready |-> prdata[31:16] == 16'h0000) else $error("upper read bits set");
   a_gap11_zero: assert property (acc_s ##0 !pwrite && paddr == 12'h000 |-> (prdata & 32'hFFFF88F8) == 0)
      else $error("gap bits in reg 11 read set");
   a_gap16_zero: assert property (acc_s ##0 !pwrite && paddr == 12'h014 |-> (prdata & 32'hFFFFF88F) == 0)
      else $error("gap bits in reg 16 read set");
   a_t6_write: assert property (wr11_s ##0 pstrb[1] |=> timer6_prio == $past(pwdata[14:12]))
      else $error("timer6 field not written");
   a_oc8_write: assert property (wr11_s ##0 pstrb[0] |=> out_compare8_prio == $past(pwdata[2:0]))
      else $error("oc8 field not written");
   a_u1_write: assert property (acc_s ##0 pwrite && paddr == 12'h014 && pstrb[0]
      |=> uart_first_error_prio == $past(pwdata[6:4])) else $error("uart1 field not written");
   a_hold_nowr: assert property (!(psel && penable && pwrite) |=> $stable(timer6_prio))
      else $error("field moved without write");
   a_en_decode: assert property (srcEnabled[0] == (timer6_prio != 3'h0)) else $error("enable decode wrong");
   a_reset_four: assert property ($fell(rst) |-> timer6_prio == 3'h4 && srcEnabled == 17'h1FFFF)
      else $error("reset level not four");
   a_err_unmapped: assert property (acc_s ##0 paddr > 12'h014 |-> pslverr && prdata == 0)
      else $error("unmapped access not refused");
endmodule
`default_nettype wire

// ---- dv/ipr_arb_model.sv ----
// Purpose: Arbitration-side model picking the highest enabled level.
// Assumes: Field i sits at bits 3i+2:3i, enable i in bit i.
// Notes:   Disabled sources never win, even at a high code.
`timescale 1ns/100ps
`default_nettype none
module ipr_arb_model (
   input  wire logic [50:0] prioVec,
   input  wire logic [16:0] enVec,
   output logic      [2:0]  topLevel
);
   always_comb begin
      topLevel = 3'h0;
      for (int i = 0; i < 17; i++) begin
         if (enVec[i] && prioVec[3*i+:3] > topLevel) begin
            topLevel = prioVec[3*i+:3];
         end
      end
   end
endmodule
`default_nettype wire

// ---- dv/tb_top.sv ----
// Purpose: Self-checking bench for the priority register block.
// Assumes: Zero-wait APB; byte addresses 4 apart from 12'h000.
// Notes:   Model walks fields in register order, top field first.
`timescale 1ns/100ps
`default_nettype none
module tb_top;
   logic        clock, rst, psel, penable, pwrite, pready, pslverr, err;
   logic [11:0] paddr;
   logic [31:0] pwdata, prdata, rd;
   logic [3:0]  pstrb;
   wire  [50:0] pv;
   wire  [16:0] en;
   wire  [2:0]  top;
   logic [50:0] pvExp;
   logic [16:0] enExp;
   logic [2:0]  topExp;
   logic [15:0] expReg [6];
   logic [15:0] mask [6] = '{ipr_pkg::MASK_IRQ_PRIORITY_CTRL_11, ipr_pkg::MASK_IRQ_PRIORITY_CTRL_12, ipr_pkg::MASK_IRQ_PRIORITY_CTRL_13,
                             ipr_pkg::MASK_IRQ_PRIORITY_CTRL_14, ipr_pkg::MASK_IRQ_PRIORITY_CTRL_15, ipr_pkg::MASK_IRQ_PRIORITY_CTRL_16};
   int          fails, nChecks, seed, r;
   ipr_regs u_ipr_regs (.clock(clock), .rst(rst), .psel(psel), .penable(penable), .pwrite(pwrite),
      .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb), .pready(pready), .prdata(prdata), .pslverr(pslverr),
      .timer6_prio(pv[2:0]), .dma_ch4_done_prio(pv[5:3]), .out_compare8_prio(pv[8:6]),
      .timer8_prio(pv[11:9]), .i2c_second_master_prio(pv[14:12]), .i2c_second_slave_prio(pv[17:15]),
      .timer7_prio(pv[20:18]), .can_second_rx_ready_prio(pv[23:21]), .ext_irq4_prio(pv[26:24]),
      .ext_irq3_prio(pv[29:27]), .timer9_prio(pv[32:30]), .codec_if_error_prio(pv[35:33]),
      .can_second_event_prio(pv[38:36]), .dma_ch5_done_prio(pv[41:39]), .codec_if_event_prio(pv[44:42]),
      .uart_second_error_prio(pv[47:45]), .uart_first_error_prio(pv[50:48]), .srcEnabled(en));
   ipr_arb_model u_ipr_arb_model (.prioVec(pv), .enVec(en), .topLevel(top));
   initial begin
      clock = 1'b0;
      forever #12.5 clock = ~clock;
   end
   task automatic chk(input logic [50:0] seen, input logic [50:0] exp);
      nChecks++;
      if (seen !== exp) begin
         fails++;
         $display("MISMATCH t=%0t seen=%h exp=%h", $time, seen, exp);
      end
   endtask
   task automatic closeOut();
      $display("checks=%0d mismatches=%0d", nChecks, fails);
      if (fails == 0 && nChecks > 0) begin
         $display("== PASSED ==");
      end else begin
         $display("== FAILED ==");
      end
      $finish;
   endtask
   // Upper data bits are always driven high so a leak into the word shows up.
   task automatic apb(input logic w, input int i, input logic [15:0] d, input logic [3:0] s);
      int n;
      n = 0;
      @(posedge clock);
      psel <= 1'b1;
      pwrite <= w;
      paddr <= 12'(i * 4);
      pwdata <= {16'hFFFF, d};
      pstrb <= s;
      @(posedge clock);
      penable <= 1'b1;
      do @(posedge clock); while (pready !== 1'b1 && ++n < 20);
      if (n >= 20) fails++;
      rd = prdata;
      err = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
   endtask
   task automatic wr(input int i, input logic [15:0] d, input logic [3:0] s);
      logic [15:0] m;
      apb(1'b1, i, d, s);
      chk(51'(err), 51'(i > 5));
      if (i < 6) begin
         m = mask[i] & {{8{s[1]}}, {8{s[0]}}};
         expReg[i] = (expReg[i] & ~m) | (d & m);
      end
   endtask
   task automatic rdAll();
      for (int i = 0; i < 7; i++) begin
         apb(1'b0, i, 16'h0000, 4'h3);
         chk(51'(rd), 51'(i < 6 ? expReg[i] : 16'h0000));
         chk(51'(err), 51'(i > 5));
      end
   endtask
   task automatic cmpOut();
      int k;
      k = 0;
      topExp = 3'h0;
      @(negedge clock);
      for (int i = 0; i < 6; i++) begin
         for (int f = 3; f >= 0; f--) begin
            if (mask[i][4*f+:3] != 0) begin
               pvExp[3*k+:3] = expReg[i][4*f+:3];
               enExp[k] = expReg[i][4*f+:3] != 3'h0;
               if (expReg[i][4*f+:3] > topExp) topExp = expReg[i][4*f+:3];
               k++;
            end
         end
      end
      chk(pv, pvExp);
      chk(51'(en), 51'(enExp));
      chk(51'(top), 51'(topExp));
   endtask
   task automatic resetAll();
      rst <= 1'b1;
      repeat (2) @(posedge clock);
      rst <= 1'b0;
      for (int i = 0; i < 6; i++) expReg[i] = mask[i] & 16'h4444;
      cmpOut();
      rdAll();
   endtask
   initial begin
      {rst, psel, penable, pwrite, paddr, pwdata, pstrb} = {1'b1, 51'h0};
      seed = 71;
      resetAll();
      for (int c = 0; c < 8; c++) begin
         for (int i = 0; i < 6; i++) wr(i, {4{1'b1, 3'(c)}}, 4'h3);
         cmpOut();
         rdAll();
      end
      repeat (60) begin
         r = {$random(seed)} % 8;
         wr(r, 16'($random(seed)), 4'($random(seed)));
         cmpOut();
      end
      rdAll();
      resetAll();
      closeOut();
   end
   initial begin
      #500000;
      fails++;
      closeOut();
   end
endmodule
bind ipr_regs ipr_regs_assertions u_ipr_regs_assertions (.clock(clock), .rst(rst), .psel(psel),
   .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb), .pready(pready),
   .prdata(prdata), .pslverr(pslverr), .timer6_prio(timer6_prio), .out_compare8_prio(out_compare8_prio),
   .uart_first_error_prio(uart_first_error_prio), .srcEnabled(srcEnabled));
`default_nettype wire
